// ### src/mscp_pkg.sv
/*
 Shared constants and types for the measurement sync and
 post-processing command block. Assumes a 32-bit register port.
*/
package mscp_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_OUT = 8'h04;
   localparam logic [7:0] OFS_STB = 8'h08;
   localparam logic [7:0] OFS_ESR = 8'h0C;
   localparam logic [7:0] OFS_SCALE = 8'h10;
   localparam logic [7:0] OFS_OFFSET = 8'h14;
   localparam logic [7:0] OFS_LIM_HI = 8'h18;
   localparam logic [7:0] OFS_LIM_LO = 8'h1C;
   localparam logic [7:0] OFS_CTRL = 8'h20;
   localparam logic [7:0] OFS_STAT = 8'h24;
   // Event and status byte bit positions
   localparam int ESR_OPC = 0;
   localparam int ESR_DDE = 3;
   localparam int ESR_CME = 5;
   localparam int STB_MAV = 4;
   localparam int STB_ESB = 5;
   localparam int STB_MSS = 6;
   // Control register bit positions
   localparam int CTL_LOCAL = 0;
   localparam int CTL_MATH = 1;
   localparam int CTL_LIMIT = 2;
   localparam int CTL_AUTO = 3;
   // Reset values and fixed figures
   localparam logic [15:0] SCALE_RST = 16'h0001;
   localparam logic [15:0] PARAM_RST = 16'h0000;
   localparam logic [7:0] COUNT_RST = 8'h0A;
   localparam logic [7:0] OPC_ANSWER = 8'h01;
   localparam int QDEPTH = 4;
   // Command opcodes
   typedef enum logic [3:0] {
      OP_NOP = 4'h0, OP_WAIT = 4'h1, OP_OPCQ = 4'h2, OP_OPC = 4'h3,
      OP_INIT = 4'h4, OP_RESET = 4'h5, OP_CLS = 4'h6, OP_ESE = 4'h7,
      OP_SRE = 4'h8, OP_STATQ = 4'h9, OP_RECOMP = 4'hA, OP_AUTO = 4'hB,
      OP_STATEN = 4'hC, OP_COUNT = 4'hD, OP_AUTOTRIG = 4'hE
   } mscp_op_t;
   // Queued command: opcode and byte argument
   typedef struct packed {
      mscp_op_t op;
      logic [7:0] arg;
   } mscp_cmd_t;
   // Post-processing settings handed to the math unit
   typedef struct packed {
      logic math_en;
      logic limit_en;
      logic [15:0] scale;
      logic [15:0] offset;
      logic [15:0] lim_hi;
      logic [15:0] lim_lo;
   } mscp_pp_cfg_t;
   // Executor states
   typedef enum logic [1:0] {
      EX_RUN = 2'b00, EX_HOLD = 2'b01, EX_OPCQ = 2'b10
   } mscp_ex_t;
endpackage : mscp_pkg

// ### src/mscp_run_ctr.sv
/*
 Measurement run tracker: counts completed measurements of one run.
 Assumes done pulses from the front end and statistics unit.
*/
`timescale 1ns/1ps
`default_nettype none
module mscp_run_ctr
   import mscp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Run control
   input wire logic start,
   input wire logic [7:0] run_len,
   input wire logic stats_en,
   // Completion pulses
   input wire logic meas_done,
   input wire logic stat_done,
   // Run state
   output logic busy,
   output logic run_done,
   output logic [7:0] meas_cnt
);
   logic busy_q, busy_d, sw_q, sw_d, done_q, done_d;
   logic [7:0] cnt_q, cnt_d;
   wire [7:0] cnt_inc = cnt_q + 8'h01; // Next measurement count
   // Zero length behaves as a single measurement
   wire [7:0] len = (run_len == 8'h00) ? 8'h01 : run_len;
   wire last = busy_q && !sw_q && meas_done && (cnt_inc == len);
   // Run ends after last measurement, or after statistics when they are enabled
   wire fin = (last && !stats_en) || (sw_q && stat_done);

   assign busy_d = start ? 1'b1 : (fin ? 1'b0 : busy_q);
   assign sw_d = start ? 1'b0 : (last && stats_en) ? 1'b1 : (fin ? 1'b0 : sw_q);
   assign cnt_d = start ? 8'h00 : (busy_q && !sw_q && meas_done) ? cnt_inc : cnt_q;
   assign done_d = fin && !start;

   // State flops, frozen while ce is low
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy_q <= 1'b0;
         sw_q <= 1'b0;
         cnt_q <= 8'h00;
         done_q <= 1'b0;
      end
      else if (ce)
      begin
         busy_q <= busy_d;
         sw_q <= sw_d;
         cnt_q <= cnt_d;
         done_q <= done_d;
      end
   end

   assign busy = busy_q;
   assign run_done = done_q;
   assign meas_cnt = cnt_q;

   a_run_count_full:
      assert property (@(posedge clk) disable iff (!rst_n) run_done |-> cnt_q == len)
      else $error("run ended before its measurement count");
endmodule : mscp_run_ctr
`default_nettype wire

// ### src/mscp_status.sv
/*
 Event status, masks and status byte with service request summary.
 Assumes one-cycle set pulses and clear strobes from the executor.
*/
`timescale 1ns/1ps
`default_nettype none
module mscp_status
   import mscp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Event inputs and controls
   input wire logic [7:0] esr_set,
   input wire logic esr_clr,
   input wire logic ese_we,
   input wire logic sre_we,
   input wire logic [7:0] mask_val,
   input wire logic mav,
   // Status outputs
   output logic [7:0] esr,
   output logic [7:0] ese,
   output logic [7:0] sre,
   output logic [7:0] stb,
   output logic srq
);
   logic [7:0] esr_q, ese_q, sre_q;
   // Hardware set wins over a clear in the same cycle
   wire [7:0] esr_d = (esr_clr ? 8'h00 : esr_q) | esr_set;
   wire esb = |(esr_q & ese_q);
   wire [7:0] stb_lo = {2'b00, esb, mav, 4'h0};
   // Request bit never enables itself
   wire mss = |(stb_lo & sre_q);

   // Event register and masks
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         esr_q <= 8'h00;
         ese_q <= 8'h00;
         sre_q <= 8'h00;
      end
      else if (ce)
      begin
         esr_q <= esr_d;
         if (ese_we)
            ese_q <= mask_val;
         if (sre_we)
            sre_q <= mask_val;
      end
   end

   assign esr = esr_q;
   assign ese = ese_q;
   assign sre = sre_q;
   assign stb = stb_lo | {1'b0, mss, 6'h00};
   assign srq = mss;
endmodule : mscp_status
`default_nettype wire

// ### src/mscp_top.sv
/*
 Command queue, executor and post-processing control of a
 measurement instrument. Assumes a register port with one-cycle
 strobes and read data one cycle later, and done pulses from the
 measurement front end and statistics unit, and a limit flag from the math unit.
*/
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Wait command holds later commands until idle
// - Commands keep queueing during a wait
// - Other instruments' traffic passes without delay
// - Completion query answers 1 when all done
// - Event mask 1 summarizes completion event
// - Request mask 32 raises service request
// - Armed completion event set at run end
// - Statistics over exactly the configured count with auto trigger on, else over one
// - One initiate runs count measurements with auto trigger on, else one
// - Statistics query queued behind a wait waits for run end
// - Reset turns automatic recompute off
// - Every new measurement refreshes the result
// - Settings writes alone never recompute when auto and local are off
// - Auto mode recomputes on each setting write
// - Auto writes apply at once, may flag
// - Recompute command gives one final result
// - Local entry enables math or limits
// - Request mask 32 selects event summary
module mscp_top
   import mscp_pkg::*;
(
   // Clock, reset and clock enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic we,
   input wire logic re,
   output logic [31:0] rdata,
   // Measurement front end and statistics unit
   output logic meas_start,
   input wire logic meas_done,
   input wire logic stat_done,
   input wire logic [7:0] stat_result,
   // Math and limit unit
   output logic recalc,
   output mscp_pp_cfg_t pp_cfg,
   input wire logic limit_fail,
   // Bus service request
   output logic srq,
   // Traffic for other instruments
   input wire logic peer_in_valid,
   input wire logic [7:0] peer_in_data,
   output logic peer_out_valid,
   output logic [7:0] peer_out_data
);
   // Opcode match, used by every command decode
   function automatic logic op_is(input mscp_cmd_t c, input mscp_op_t o);
      return c.op == o;
   endfunction : op_is

   // Register strobes
   wire wr_cmd = we && (addr == OFS_CMD);
   wire wr_scale = we && (addr == OFS_SCALE);
   wire wr_offset = we && (addr == OFS_OFFSET);
   wire wr_hi = we && (addr == OFS_LIM_HI);
   wire wr_lo = we && (addr == OFS_LIM_LO);
   wire wr_ctrl = we && (addr == OFS_CTRL);
   wire rd_out = re && (addr == OFS_OUT);
   wire rd_esr = re && (addr == OFS_ESR);
   wire wr_math = wr_scale || wr_offset; // Scale or offset write
   wire wr_lim = wr_hi || wr_lo; // Limit write
   wire param_we = wr_math || wr_lim; // Any setting write

   // Command queue storage and pointers
   mscp_cmd_t q_mem [QDEPTH];
   logic [1:0] wp_q, rp_q;
   logic [2:0] qc_q, qc_d;
   // Executor state
   mscp_ex_t ex_q, ex_d;
   // Output buffer
   logic [7:0] out_q, out_d;
   logic out_v_q, out_v_d;
   // Run configuration
   logic stats_en_q, autotrig_q;
   logic [7:0] count_q;
   // Post-processing settings
   logic [15:0] scale_q, offset_q, hi_q, lo_q;
   logic math_q, limit_q, auto_q, local_q;
   // Completion event arming and pulses
   logic opc_arm_q, recalc_q, start_q;
   logic peer_v_q;
   logic [7:0] peer_d_q;
   logic [31:0] rdata_q;
   // Wires from the two helper units
   logic run_busy, run_done;
   logic [7:0] meas_cnt, esr, ese, sre, stb;

   // Queue head and push/pop
   wire mscp_cmd_t head = q_mem[rp_q];
   wire q_full = (qc_q == 3'(QDEPTH));
   wire q_has = (qc_q != 3'h0);
   // Commands are taken in even while execution is held
   wire push = wr_cmd && !q_full;
   wire overflow = wr_cmd && q_full;
   // Only a running executor may issue the head
   wire exec_go = q_has && (ex_q == EX_RUN);
   wire pop = exec_go;
   wire fire_wait = exec_go && op_is(head, OP_WAIT);
   wire fire_opcq = exec_go && op_is(head, OP_OPCQ);
   wire fire_opc = exec_go && op_is(head, OP_OPC);
   wire fire_init = exec_go && op_is(head, OP_INIT);
   wire fire_reset = exec_go && op_is(head, OP_RESET);
   wire fire_cls = exec_go && op_is(head, OP_CLS);
   wire fire_ese = exec_go && op_is(head, OP_ESE);
   wire fire_sre = exec_go && op_is(head, OP_SRE);
   wire fire_statq = exec_go && op_is(head, OP_STATQ);
   wire fire_recomp = exec_go && op_is(head, OP_RECOMP);
   wire fire_auto = exec_go && op_is(head, OP_AUTO);
   wire fire_staten = exec_go && op_is(head, OP_STATEN);
   wire fire_count = exec_go && op_is(head, OP_COUNT);
   wire fire_trig = exec_go && op_is(head, OP_AUTOTRIG);
   // Query answer once nothing is pending
   wire opcq_done = (ex_q == EX_OPCQ) && !run_busy;

   // Queue count
   assign qc_d = qc_q + 3'(push) - 3'(pop);

   // Executor transitions
   always_comb
   begin
      ex_d = ex_q;
      unique case (ex_q)
         EX_RUN:
         begin
            if (fire_wait)
               ex_d = EX_HOLD;
            else if (fire_opcq)
               ex_d = EX_OPCQ;
         end
         EX_HOLD:
         begin
            // Release only when the run and its statistics are done
            if (!run_busy)
               ex_d = EX_RUN;
         end
         EX_OPCQ:
         begin
            if (!run_busy)
               ex_d = EX_RUN;
         end
         default: ex_d = EX_RUN;
      endcase
   end

   // Output buffer: a new answer replaces an unread one
   assign out_d = opcq_done ? OPC_ANSWER : (fire_statq ? stat_result : out_q);
   assign out_v_d = (opcq_done || fire_statq) || (out_v_q && !rd_out);

   // Queue storage, one slot per generate step
   genvar gi;
   generate
      for (gi = 0; gi < QDEPTH; gi++)
      begin : g_slot
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               q_mem[gi] <= '0;
            else if (ce && push && (wp_q == 2'(gi)))
               q_mem[gi] <= wdata[11:0];
         end
      end
   endgenerate

   // Queue pointers, executor state and answer buffer
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wp_q <= 2'h0;
         rp_q <= 2'h0;
         qc_q <= 3'h0;
         ex_q <= EX_RUN;
         out_q <= 8'h00;
         out_v_q <= 1'b0;
      end
      else if (ce)
      begin
         wp_q <= wp_q + 2'(push);
         rp_q <= rp_q + 2'(pop);
         qc_q <= qc_d;
         ex_q <= ex_d;
         out_q <= out_d;
         out_v_q <= out_v_d;
      end
   end

   // Run configuration and completion arming
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stats_en_q <= 1'b0;
         autotrig_q <= 1'b0;
         count_q <= COUNT_RST;
         opc_arm_q <= 1'b0;
         start_q <= 1'b0;
      end
      else if (ce)
      begin
         stats_en_q <= fire_reset ? 1'b0 : (fire_staten ? head.arg[0] : stats_en_q);
         autotrig_q <= fire_reset ? 1'b0 : (fire_trig ? head.arg[0] : autotrig_q);
         count_q <= fire_count ? head.arg : count_q;
         // Arm on the command, fire at the end of the following run
         opc_arm_q <= fire_opc || (opc_arm_q && !run_done && !fire_cls);
         start_q <= fire_init;
      end
   end

   // Length of the run that one initiate starts
   wire [7:0] run_len = autotrig_q ? count_q : 8'h01;

   // Run tracker
   mscp_run_ctr u_run (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .start(fire_init),
      .run_len(run_len),
      .stats_en(stats_en_q),
      .meas_done(meas_done),
      .stat_done(stat_done),
      .busy(run_busy),
      .run_done(run_done),
      .meas_cnt(meas_cnt)
   );

   // Events into the status register
   wire [7:0] esr_set = (8'(opc_arm_q && run_done) << ESR_OPC)
                      | (8'(limit_fail) << ESR_DDE)
                      | (8'(overflow) << ESR_CME);

   // Status register, masks and service request
   mscp_status u_stat (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .esr_set(esr_set),
      .esr_clr(rd_esr || fire_cls),
      .ese_we(fire_ese),
      .sre_we(fire_sre),
      .mask_val(head.arg),
      .mav(out_v_q),
      .esr(esr),
      .ese(ese),
      .sre(sre),
      .stb(stb),
      .srq(srq)
   );

   // Settings with local-entry auto enables
   wire math_set = local_q && wr_scale;
   wire limit_set = local_q && wr_lim;
   // Recompute causes; nothing else may recompute
   wire recalc_d = meas_done
                 || (param_we && (auto_q || local_q))
                 || fire_recomp;

   // Post-processing settings
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scale_q <= SCALE_RST;
         offset_q <= PARAM_RST;
         hi_q <= PARAM_RST;
         lo_q <= PARAM_RST;
         math_q <= 1'b0;
         limit_q <= 1'b0;
         auto_q <= 1'b0;
         local_q <= 1'b0;
         recalc_q <= 1'b0;
      end
      else if (ce)
      begin
         // Each setting write lands at once, no staging
         if (wr_scale)
            scale_q <= wdata[15:0];
         if (wr_offset)
            offset_q <= wdata[15:0];
         if (wr_hi)
            hi_q <= wdata[15:0];
         if (wr_lo)
            lo_q <= wdata[15:0];
         if (fire_reset)
         begin
            auto_q <= 1'b0;
            math_q <= 1'b0;
            limit_q <= 1'b0;
         end
         else if (wr_ctrl)
         begin
            math_q <= wdata[CTL_MATH];
            limit_q <= wdata[CTL_LIMIT];
            auto_q <= wdata[CTL_AUTO];
         end
         else
         begin
            math_q <= math_q || math_set;
            limit_q <= limit_q || limit_set;
            auto_q <= fire_auto ? head.arg[0] : auto_q;
         end
         if (wr_ctrl)
            local_q <= wdata[CTL_LOCAL];
         recalc_q <= recalc_d;
      end
   end

   // Traffic for other instruments never sees the hold
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         peer_v_q <= 1'b0;
         peer_d_q <= 8'h00;
      end
      else if (ce)
      begin
         peer_v_q <= peer_in_valid;
         peer_d_q <= peer_in_data;
      end
   end

   // Read data select
   wire [31:0] rd_mux =
      (addr == OFS_OUT) ? {23'h0, out_v_q, out_q} :
      (addr == OFS_STB) ? {24'h0, stb} :
      (addr == OFS_ESR) ? {24'h0, esr} :
      (addr == OFS_SCALE) ? {16'h0, scale_q} :
      (addr == OFS_OFFSET) ? {16'h0, offset_q} :
      (addr == OFS_LIM_HI) ? {16'h0, hi_q} :
      (addr == OFS_LIM_LO) ? {16'h0, lo_q} :
      (addr == OFS_CTRL) ? {28'h0, auto_q, limit_q, math_q, local_q} :
      (addr == OFS_STAT) ? {8'h0, meas_cnt, ese, 1'b0, qc_q, opc_arm_q, run_busy, ex_q} :
      32'h0000_0000;

   // Read data register, valid the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_q <= 32'h0000_0000;
      else if (ce && re)
         rdata_q <= rd_mux;
   end

   assign rdata = rdata_q;
   assign meas_start = start_q;
   assign recalc = recalc_q;
   assign pp_cfg = '{math_q, limit_q, scale_q, offset_q, hi_q, lo_q};
   assign peer_out_valid = peer_v_q;
   assign peer_out_data = peer_d_q;

   // Checks on the command path and status
   a_wait_holds_exec:
      assert property (@(posedge clk) disable iff (!rst_n)
         ce && fire_wait && run_busy |=> ex_q == EX_HOLD ##0 !exec_go)
      else $error("wait did not hold execution");
   a_queue_accepts_held:
      assert property (@(posedge clk) disable iff (!rst_n)
         ce && push && !pop |=> qc_q == $past(qc_q) + 3'h1)
      else $error("command lost while held");
   a_peer_no_delay:
      assert property (@(posedge clk) disable iff (!rst_n)
         ce && peer_in_valid |=> peer_out_valid && peer_out_data == $past(peer_in_data))
      else $error("peer traffic delayed");
   a_opcq_answer_one:
      assert property (@(posedge clk) disable iff (!rst_n)
         ce && opcq_done |=> out_v_q && out_q == OPC_ANSWER)
      else $error("completion query did not answer 1");
   a_query_waits_run:
      assert property (@(posedge clk) disable iff (!rst_n)
         ex_q != EX_RUN && run_busy |-> !fire_statq && !out_v_d || out_v_q)
      else $error("query ran before run end");
   a_srq_from_esb:
      assert property (@(posedge clk) disable iff (!rst_n)
         sre[STB_ESB] && (|(esr & ese)) |-> srq && stb[STB_ESB])
      else $error("event summary did not raise request");
   a_opc_event_set:
      assert property (@(posedge clk) disable iff (!rst_n)
         ce && opc_arm_q && run_done |=> esr[ESR_OPC])
      else $error("armed completion event not set");
   a_reset_auto_off:
      assert property (@(posedge clk) disable iff (!rst_n)
         ce && fire_reset |=> !auto_q)
      else $error("reset left auto recompute on");
   a_meas_recalc:
      assert property (@(posedge clk) disable iff (!rst_n)
         ce && meas_done |=> recalc)
      else $error("new measurement not recomputed");
   a_no_silent_recalc:
      assert property (@(posedge clk) disable iff (!rst_n)
         ce && !meas_done && !fire_recomp && !(param_we && (auto_q || local_q)) |=> !recalc)
      else $error("recompute without cause");
   c_wait_release: cover property (@(posedge clk) ex_q == EX_HOLD ##1 ex_q == EX_RUN);
   c_opcq_answer: cover property (@(posedge clk) opcq_done);
   c_srq_raised: cover property (@(posedge clk) $rose(srq));
endmodule : mscp_top
`default_nettype wire

// ### test/mscp_fe_model.sv
/*
 Front-end model: answers a run start with measurement done pulses.
 Assumes the bench sets the run length and the gap between pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module mscp_fe_model
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Run setup from the bench
   input wire logic [7:0] n_meas,
   input wire logic [7:0] gap,
   // Handshake with the block
   input wire logic meas_start,
   output logic meas_done,
   output logic stat_done
);
   logic [7:0] left_q; // Measurements still owed
   logic [7:0] tmr_q; // Cycles to the next measurement
   logic sdue_q; // Statistics pulse still owed
   // Each measurement takes gap+1 cycles, so a large gap makes a slow front end
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         {left_q, tmr_q, sdue_q, meas_done, stat_done} <= '0;
      else
      begin
         meas_done <= 1'b0;
         stat_done <= 1'b0;
         if (meas_start)
         begin
            left_q <= n_meas;
            tmr_q <= gap;
         end
         else if (left_q != 8'h00 && tmr_q != 8'h00)
            tmr_q <= tmr_q - 8'h01;
         else if (left_q != 8'h00)
         begin
            meas_done <= 1'b1;
            left_q <= left_q - 8'h01;
            tmr_q <= gap;
            sdue_q <= (left_q == 8'h01);
         end
         else if (sdue_q)
         begin
            stat_done <= 1'b1; // Late, after the last measurement
            sdue_q <= 1'b0;
         end
      end
   end
endmodule : mscp_fe_model
`default_nettype wire

// ### test/mscp_top_tb_top.sv
/*
 Bench for mscp_top: register tasks and one task per scenario.
 Assumes the front-end model and the shared package.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
   begin \
      checks_done++; \
      if ((g) !== (e)) \
         begin n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end \
   end
module mscp_top_tb_top
   import mscp_pkg::*;
;
   // Clock, reset and register port
   logic clk = 0, rst_n = 0, we = 0, re = 0;
   logic [7:0] addr = '0, nm = 8'h01, gap = 8'h03;
   logic [31:0] wdata = '0, rdata, rv;
   // Front end, math unit and peer traffic
   logic meas_start, meas_done, stat_done, recalc, srq, peer_in_valid = 0, peer_out_valid;
   logic [7:0] peer_in_data = '0, peer_out_data;
   mscp_pp_cfg_t pp_cfg;
   int n_errors = 0, checks_done = 0, n_recalc = 0, base;
   always #2.5 clk = ~clk;
   // Count recompute pulses seen; the falling edge keeps clear of the edge that launches them
   always @(negedge clk)
      if (recalc === 1'b1)
         n_recalc++;
   mscp_top u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .addr(addr), .wdata(wdata), .we(we),
      .re(re), .rdata(rdata), .meas_start(meas_start), .meas_done(meas_done), .stat_done(stat_done),
      .stat_result(8'hA5), .recalc(recalc), .pp_cfg(pp_cfg), .limit_fail(1'b0), .srq(srq),
      .peer_in_valid(peer_in_valid), .peer_in_data(peer_in_data), .peer_out_valid(peer_out_valid),
      .peer_out_data(peer_out_data));
   mscp_fe_model u_fe (.clk(clk), .rst_n(rst_n), .n_meas(nm), .gap(gap), .meas_start(meas_start),
      .meas_done(meas_done), .stat_done(stat_done));
   task automatic print_verdict;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict
   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
   endtask : wr
   // Read data stand from the cycle after the strobe until the next read
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1 rv = rdata;
   endtask : rd
   task automatic cmd(input mscp_op_t op, input logic [7:0] arg);
      wr(OFS_CMD, {20'h0_0000, op, arg});
   endtask : cmd
   // Poll until executor runs, queue empty and run idle
   task automatic wait_idle;
      for (int i = 0; i < 300; i++)
      begin
         rd(OFS_STAT);
         if (rv[2:0] == 3'h0 && rv[6:4] == 3'h0)
            return;
      end
      n_errors++;
      print_verdict;
   endtask : wait_idle
   task automatic sc_reset;
      `CHK("scale", SCALE_RST, pp_cfg.scale)
      `CHK("srq", 1'b0, srq)
      rd(8'h3C);
      `CHK("unmapped", 32'h0000_0000, rv)
      cmd(OP_RESET, 8'h00);
      cmd(OP_CLS, 8'h00);
      cmd(OP_SRE, 8'h00);
      cmd(OP_ESE, 8'h00);
      wait_idle;
   endtask : sc_reset
   // Run of three, held query behind a wait, peer traffic meanwhile
   task automatic sc_wait;
      cmd(OP_STATEN, 8'h01);
      cmd(OP_COUNT, 8'h03);
      cmd(OP_AUTOTRIG, 8'h01);
      nm = 8'h03;
      gap = 8'h08;
      cmd(OP_INIT, 8'h00);
      cmd(OP_WAIT, 8'h00);
      cmd(OP_STATQ, 8'h00);
      rd(OFS_STAT);
      `CHK("held", 2'h1, rv[1:0])
      `CHK("queued", 3'h1, rv[6:4])
      @(posedge clk);
      peer_in_valid <= 1'b1;
      peer_in_data <= 8'h3C;
      @(posedge clk);
      peer_in_valid <= 1'b0;
      #1 `CHK("peer", 9'h13C, {peer_out_valid, peer_out_data})
      rd(OFS_OUT);
      `CHK("early out", 1'b0, rv[8])
      wait_idle;
      `CHK("meas count", 8'h03, rv[23:16])
      rd(OFS_OUT);
      `CHK("stats", 9'h1A5, rv[8:0])
   endtask : sc_wait
   task automatic sc_opcq;
      gap = 8'h10;
      cmd(OP_INIT, 8'h00);
      cmd(OP_OPCQ, 8'h00);
      rd(OFS_STAT);
      `CHK("busy", 1'b1, rv[2])
      rd(OFS_OUT);
      `CHK("opc early", 1'b0, rv[8])
      // Host blocks on polling until the device is idle, then reads the answer
      wait_idle;
      rd(OFS_OUT);
      `CHK("opc answer", {1'b1, OPC_ANSWER}, rv[8:0])
   endtask : sc_opcq
   // Armed completion event raises the request through both masks
   task automatic sc_srq;
      gap = 8'h02;
      cmd(OP_ESE, 8'h01);
      cmd(OP_SRE, 8'h20);
      cmd(OP_OPC, 8'h00);
      cmd(OP_INIT, 8'h00);
      `CHK("srq early", 1'b0, srq)
      for (int i = 0; i < 100 && srq !== 1'b1; i++)
         @(posedge clk);
      `CHK("srq", 1'b1, srq)
      // Status byte read stands in for the serial poll
      rd(OFS_STB);
      `CHK("stb", 8'h60, rv[7:0] & 8'h60)
      rd(OFS_ESR);
      `CHK("esr", 1'b1, rv[ESR_OPC])
      #1 `CHK("srq off", 1'b0, srq)
   endtask : sc_srq
   // Recompute only when asked, on auto writes, and on new results
   task automatic sc_math;
      cmd(OP_RESET, 8'h00);
      wait_idle;
      base = n_recalc;
      wr(OFS_SCALE, 32'h0000_0002);
      wr(OFS_OFFSET, 32'h0000_0003);
      repeat (4) @(posedge clk);
      `CHK("quiet", base, n_recalc)
      `CHK("scale", 16'h0002, pp_cfg.scale)
      cmd(OP_RECOMP, 8'h00);
      wait_idle;
      `CHK("once", base + 1, n_recalc)
      cmd(OP_AUTO, 8'h01);
      wait_idle;
      base = n_recalc;
      wr(OFS_LIM_HI, 32'h0000_0009);
      wr(OFS_LIM_LO, 32'h0000_0001);
      repeat (4) @(posedge clk);
      `CHK("auto", base + 2, n_recalc)
      cmd(OP_AUTO, 8'h00);
      nm = 8'h01;
      wait_idle;
      base = n_recalc;
      cmd(OP_INIT, 8'h00);
      wait_idle;
      `CHK("new meas", base + 1, n_recalc)
      wr(OFS_CTRL, 32'h0000_0001);
      wr(OFS_LIM_HI, 32'h0000_0007);
      wr(OFS_SCALE, 32'h0000_0004);
      repeat (2) @(posedge clk);
      `CHK("local", 2'h3, {pp_cfg.math_en, pp_cfg.limit_en})
   endtask : sc_math
   // Hang guard
   initial
   begin
      repeat (40000) @(posedge clk);
      n_errors++;
      print_verdict;
   end
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      sc_reset;
      sc_wait;
      sc_opcq;
      sc_srq;
      sc_math;
      print_verdict;
   end
endmodule : mscp_top_tb_top
`default_nettype wire
